// ---- rtl/dbr_bus_arbiter.sv ----
// processor-side bus request arbiter with bus float and return
// Behaviour
// R1 - processor owns bus by default, always retakes
// R2 - processor never requests; only grants, then waits
// R3 - requester pulls shared request line low
// R4 - requester checks line; if low, retries later
// R5 - requester may request when line high
// R6 - grant output low means bus given up
// R7 - grant chain in fed from higher chain out
// R8 - grant ripples to highest-priority requester
// R9 - requester waits for grant, holding request low
// R10 - requester releases line, then passes grant down
// R11 - losing requesters hold requests, served in turn
// R12 - no retake while request line stays low
// R13 - all bus outputs floated while granted away
// R14 - owning requester drives all bus signals
// R15 - grant within 3 to 20 cycles of request
// R16 - grant high within 1-2 cycles of release
// R17 - idle requester passes grant; requester blocks it
// R18 - request line only pulled low or left floating
`timescale 1ns/10ps
`include "dbr_consts.svh"

module dbr_bus_arbiter #(
  parameter int CNT_W = `DBR_CNT_W
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic bus_request_line_n,
  input wire logic core_idle,
  input wire dbr_pkg::dbr_word_t core_addr_data,
  input wire dbr_pkg::dbr_status_t core_status,
  input wire logic core_address_strobe_n,
  input wire logic core_data_strobe_n,
  input wire logic core_read_write,
  input wire logic core_byte_word,
  input wire logic core_normal_system,
  input wire logic core_memory_request_n,
  output logic bus_grant_out_n,
  output logic core_hold,
  output dbr_pkg::dbr_word_t addr_data_bus,
  output dbr_pkg::dbr_status_t status_code_lines,
  output logic address_strobe_n,
  output logic data_strobe_n,
  output logic read_write,
  output logic byte_word,
  output logic normal_system,
  output logic memory_request_strobe,
  output logic bus_oe
);
  import dbr_pkg::*;

  // ----------------------------------------------------------------
  // state and counter
  // ----------------------------------------------------------------
  dbr_state_t state_ff;
  dbr_state_t nxt_state;
  logic [CNT_W-1:0] lat_cnt;

  logic grant_n_ff;
  logic nxt_grant_n;
  logic hold_ff;
  logic nxt_hold;
  logic oe_ff;
  logic nxt_oe;

  dbr_word_t ad_ff;
  dbr_status_t st_ff;
  logic [5:0] ctl_ff;

  // the line is wired-or with a pull-up; this end only listens [R18]
  wire req_seen = !bus_request_line_n;
  wire in_own = (state_ff == dbr_st_own);
  wire in_drain = (state_ff == dbr_st_drain);
  wire in_granted = (state_ff == dbr_st_granted);
  wire in_return = (state_ff == dbr_st_return);

  wire min_met = lat_cnt >= CNT_W'(`DBR_GRANT_MIN_CYC - 5'h01);
  wire max_hit = lat_cnt >= CNT_W'(`DBR_GRANT_MAX_CYC - 5'h01);
  // give up the bus once the core is between cycles, or forced at the
  // ceiling; the core must reach idle by then or its cycle is cut [R15]
  wire grant_now = req_seen && ((core_idle && min_met) || max_hit);

  dbr_latency_counter #(
    .CNT_W(CNT_W)
  ) u_lat (
    .clk(clk),
    .sys_rst(sys_rst),
    .clear(!in_drain),
    .count_en(in_drain),
    .count(lat_cnt)
  );

  // ----------------------------------------------------------------
  // sequencing
  // ----------------------------------------------------------------
  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      // bus is only ever handed out, never fetched for the core [R2]
      dbr_st_own: begin
        if (req_seen) nxt_state = dbr_st_drain;
      end
      dbr_st_drain: begin
        // a withdrawn request leaves the core in charge [R1]
        if (!req_seen) nxt_state = dbr_st_own;
        else if (grant_now) nxt_state = dbr_st_granted;
      end
      dbr_st_granted: begin
        // stay away while any requester still pulls the line [R12]
        if (!req_seen) nxt_state = dbr_st_return;
      end
      dbr_st_return: begin
        // a waiting requester picks up the grant in turn [R12]
        if (req_seen) nxt_state = dbr_st_granted;
        else nxt_state = dbr_st_own;
      end
    endcase
  end

  // grant low heads the chain and floats every bus output [R6] [R13]
  assign nxt_grant_n = !(nxt_state == dbr_st_granted ||
                         nxt_state == dbr_st_return);
  // grant back high two cycles after release seen, bus retaken [R16] [R1]
  // core keeps the bus through the drain so its cycle can finish
  assign nxt_oe = nxt_grant_n;
  assign nxt_hold = (nxt_state != dbr_st_own);

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_ff <= dbr_st_own;
      grant_n_ff <= 1'b1;
      hold_ff <= 1'b0;
      oe_ff <= 1'b1;
    end else begin
      state_ff <= nxt_state;
      grant_n_ff <= nxt_grant_n;
      hold_ff <= nxt_hold;
      oe_ff <= nxt_oe;
    end
  end

  // ----------------------------------------------------------------
  // bus output registers
  // ----------------------------------------------------------------
  // values keep tracking the core; only the enable decides the float
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      ad_ff <= 16'h0000;
      st_ff <= 4'h0;
      ctl_ff <= 6'h2f;
    end else begin
      ad_ff <= core_addr_data;
      st_ff <= core_status;
      ctl_ff <= {core_address_strobe_n, core_data_strobe_n,
                 core_read_write, core_byte_word,
                 core_normal_system, core_memory_request_n};
    end
  end

  assign bus_grant_out_n = grant_n_ff;
  assign core_hold = hold_ff;
  assign bus_oe = oe_ff;
  assign addr_data_bus = ad_ff;
  assign status_code_lines = st_ff;
  assign address_strobe_n = ctl_ff[5];
  assign data_strobe_n = ctl_ff[4];
  assign read_write = ctl_ff[3];
  assign byte_word = ctl_ff[2];
  assign normal_system = ctl_ff[1];
  assign memory_request_strobe = ctl_ff[0];

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  property p_default_owner;
    bus_request_line_n [*4] |-> bus_oe && bus_grant_out_n;
  endproperty
  a_default_owner: assert property (p_default_owner) // [R1]
    else $error("bus not retaken after requests ended");

  property p_grant_needs_req;
    $fell(bus_grant_out_n) |-> !$past(bus_request_line_n);
  endproperty
  a_grant_needs_req: assert property (p_grant_needs_req) // [R2]
    else $error("grant given with no request on the line");

  property p_grant_floats;
    $fell(bus_grant_out_n) |-> $fell(bus_oe);
  endproperty
  a_grant_floats: assert property (p_grant_floats) // [R6]
    else $error("grant and bus float not simultaneous");

  property p_float_granted;
    !bus_grant_out_n |-> !bus_oe && core_hold;
  endproperty
  a_float_granted: assert property (p_float_granted) // [R13]
    else $error("bus driven while granted away");

  property p_hold_while_req;
    !bus_grant_out_n && !bus_request_line_n |=> !bus_grant_out_n;
  endproperty
  a_hold_while_req: assert property (p_hold_while_req) // [R12]
    else $error("bus retaken while request line low");

  property p_lat_min;
    (in_own && !bus_request_line_n) ##1 (!bus_request_line_n) [*3]
      |-> bus_grant_out_n;
  endproperty
  a_lat_min: assert property (p_lat_min) // [R15]
    else $error("grant sooner than three cycles");

  property p_lat_max;
    in_drain |-> lat_cnt <= CNT_W'(`DBR_GRANT_MAX_CYC - 5'h01);
  endproperty
  a_lat_max: assert property (p_lat_max) // [R15]
    else $error("grant later than twenty cycles");

  property p_release_fast;
    !bus_grant_out_n && bus_request_line_n ##1 bus_request_line_n
      |=> bus_grant_out_n && bus_oe;
  endproperty
  a_release_fast: assert property (p_release_fast) // [R16]
    else $error("grant not raised within two cycles of release");

  property p_release_not_zero;
    in_granted && bus_request_line_n |=> !bus_grant_out_n;
  endproperty
  a_release_not_zero: assert property (p_release_not_zero) // [R16]
    else $error("grant raised in the same cycle as release");

  c_grant: cover property ($fell(bus_grant_out_n));
  c_return: cover property ($rose(bus_grant_out_n));
  c_withdraw: cover property (in_drain ##1 in_own);
  c_next_req: cover property (in_return ##1 in_granted);

endmodule : dbr_bus_arbiter

// ---- rtl/dbr_consts.svh ----
// timing counts for the dma bus request arbiter
`ifndef DBR_CONSTS_SVH
`define DBR_CONSTS_SVH

// width of the grant latency counter
`define DBR_CNT_W 5
// least request-to-grant latency, clock cycles
`define DBR_GRANT_MIN_CYC 5'h03
// longest request-to-grant latency, clock cycles
`define DBR_GRANT_MAX_CYC 5'h14
// counter reset value
`define DBR_CNT_RST 5'h00

`endif

// ---- rtl/dbr_latency_counter.sv ----
// saturating cycle counter for the grant latency window
`timescale 1ns/10ps
`include "dbr_consts.svh"

module dbr_latency_counter #(
  parameter int CNT_W = `DBR_CNT_W
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic clear,
  input wire logic count_en,
  output logic [CNT_W-1:0] count
);

  logic [CNT_W-1:0] count_ff;
  logic [CNT_W-1:0] nxt_count;
  wire at_top = &count_ff;

  // saturate so a stalled drain can never wrap back to a short count
  assign nxt_count = clear ? '0 :
                     (count_en && !at_top) ? count_ff + 1'b1 : count_ff;
  assign count = count_ff;

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) count_ff <= CNT_W'(`DBR_CNT_RST);
    else count_ff <= nxt_count;
  end

endmodule : dbr_latency_counter

// ---- rtl/dbr_pkg.sv ----
// types for the dma bus request arbiter
package dbr_pkg;

  typedef logic [15:0] dbr_word_t;
  typedef logic [3:0] dbr_status_t;

  typedef enum logic [3:0] {
    dbr_st_own     = 4'h1,
    dbr_st_drain   = 4'h2,
    dbr_st_granted = 4'h4,
    dbr_st_return  = 4'h8
  } dbr_state_t;

endpackage : dbr_pkg

// ---- verif/dbr_dma_model.sv ----
// two dma requesters on the shared request line and grant chain
`timescale 1ns/10ps
module dbr_dma_model #(
  parameter int LEN = 4
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [1:0] want,
  input wire logic line_n,
  input wire logic grant_chain_top_n,
  output logic [1:0] pull_low,
  output logic [1:0] served
);
  // ---------------------------------------------
  // requester state, device 0 has top priority
  // ---------------------------------------------
  logic [1:0] req_ff;
  logic [1:0] own_ff;
  logic [3:0] cnt_ff [2];
  logic [1:0] chain_in_n;
  // open-drain pull only; the pull-up lives in the bench
  assign pull_low = req_ff;
  assign chain_in_n[0] = grant_chain_top_n;
  // a requester blocks the grant, an idle one passes it
  assign chain_in_n[1] = req_ff[0] | chain_in_n[0];
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      req_ff <= 2'h0;
      own_ff <= 2'h0;
      served <= 2'h0;
      cnt_ff <= '{4'h0, 4'h0};
    end else begin
      for (int i = 0; i < 2; i++) begin
        if (!want[i]) begin
          served[i] <= 1'b0;
        end
        // only a high line may be claimed
        if (!req_ff[i] && want[i] && !served[i] && line_n) begin
          req_ff[i] <= 1'b1;
        end else if (req_ff[i] && !own_ff[i] && !chain_in_n[i]) begin
          own_ff[i] <= 1'b1;
          cnt_ff[i] <= 4'h0;
        end else if (own_ff[i]) begin
          cnt_ff[i] <= cnt_ff[i] + 4'h1;
          if (cnt_ff[i] == 4'(LEN - 1)) begin
            own_ff[i] <= 1'b0;
            req_ff[i] <= 1'b0;
            served[i] <= 1'b1;
          end
        end
      end
    end
  end
endmodule : dbr_dma_model

// ---- verif/tb_top.sv ----
// self-checking bench for the dma bus request arbiter
`timescale 1ns/10ps
module tb_top;
  import dbr_pkg::*;
  logic clk = 0, sys_rst = 1, core_idle = 1, tb_pull = 0;
  logic [1:0] want = 0, pull_low, served;
  logic [5:0] ctl = 6'h2f;
  dbr_word_t cad = 0, adb;
  dbr_status_t cst = 0, stl;
  logic gnt_n, hold, as_n, ds_n, rw, bw, ns, mrq, oe;
  wire line_n = ~(|pull_low | tb_pull);
  int n_errors = 0, num_checks = 0, k;
  always #5 clk = ~clk;
  dbr_bus_arbiter i_dbr_bus_arbiter (.clk(clk), .sys_rst(sys_rst),
    .bus_request_line_n(line_n), .core_idle(core_idle),
    .core_addr_data(cad), .core_status(cst),
    .core_address_strobe_n(ctl[5]), .core_data_strobe_n(ctl[4]),
    .core_read_write(ctl[3]), .core_byte_word(ctl[2]),
    .core_normal_system(ctl[1]), .core_memory_request_n(ctl[0]),
    .bus_grant_out_n(gnt_n), .core_hold(hold), .addr_data_bus(adb),
    .status_code_lines(stl), .address_strobe_n(as_n),
    .data_strobe_n(ds_n), .read_write(rw), .byte_word(bw),
    .normal_system(ns), .memory_request_strobe(mrq), .bus_oe(oe));
  dbr_dma_model i_dbr_dma_model (.clk(clk), .sys_rst(sys_rst),
    .want(want), .line_n(line_n), .grant_chain_top_n(gnt_n),
    .pull_low(pull_low), .served(served));
  // ---------------------------------------------
  // helpers
  // ---------------------------------------------
  task chk(string nm, logic [31:0] seen, logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("BAD %s exp %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task cnt_gnt(logic lvl);
    k = 0;
    do begin @(posedge clk); #1; k++; end while (gnt_n !== lvl && k < 40);
  endtask : cnt_gnt
  task line_to(logic lvl);
    while (line_n !== lvl) begin @(posedge clk); #1; end
  endtask : line_to
  task results;
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : results
  // ---------------------------------------------
  // scenarios
  // ---------------------------------------------
  task t_values;
    @(posedge clk) begin cad <= 16'ha5c3; cst <= 4'h9; ctl <= 6'h12; end
    @(posedge clk) #1;
    chk("bus", {adb, stl, as_n, ds_n, rw, bw, ns, mrq, oe},
        {16'ha5c3, 4'h9, 6'h12, 1'b1});
  endtask : t_values
  task t_single;
    @(posedge clk) want <= 2'b01;
    line_to(0);
    cnt_gnt(0);
    chk("grant_lat", k, 4);
    chk("hold_oe", {hold, oe}, 2'b10);
    line_to(1);
    cnt_gnt(1);
    chk("ret_lat", k, 2);
    chk("ret_hold_oe", {hold, oe}, 2'b01);
    @(posedge clk) want <= 2'b00;
  endtask : t_single
  task t_contend;
    @(posedge clk) begin want <= 2'b11; core_idle <= 0; end
    line_to(0);
    @(posedge clk) #1;
    chk("drain", {gnt_n, hold, oe}, 3'b111);
    cnt_gnt(0);
    chk("forced_lat", k, 20);
    line_to(1);
    chk("both_served", {gnt_n, served}, 3'b011);
    cnt_gnt(1);
    chk("ret_lat2", k, 2);
    @(posedge clk) begin want <= 2'b00; core_idle <= 1; end
  endtask : t_contend
  // late requester retries, pulls the line in the return cycle and takes over the grant with no gap
  task t_retry;
    logic hi;
    hi = 1'b0;
    @(posedge clk) want <= 2'b01;
    line_to(0);
    @(posedge clk) want <= 2'b11;
    cnt_gnt(0);
    chk("retry_wait", pull_low, 2'b01);
    k = 0;
    while (served[1] !== 1'b1 && k < 60) begin
      @(posedge clk);
      #1;
      k++;
      hi = hi | gnt_n;
    end
    chk("no_gap", {hi, served}, 3'b011);
    cnt_gnt(1);
    chk("ret_lat3", k, 2);
    @(posedge clk) want <= 2'b00;
  endtask : t_retry
  // reset while granted away hands the bus straight back
  task t_reset;
    @(posedge clk) want <= 2'b01;
    cnt_gnt(0);
    @(posedge clk) sys_rst <= 1;
    #1;
    chk("rst_out", {gnt_n, hold, oe}, 3'b101);
    @(posedge clk) begin sys_rst <= 0; want <= 2'b00; end
    @(posedge clk) #1;
    chk("rst_idle", {gnt_n, hold, oe, line_n}, 4'b1011);
  endtask : t_reset
  task t_refuse;
    @(posedge clk) tb_pull <= 1;
    repeat (2) @(posedge clk);
    tb_pull <= 0;
    repeat (3) @(posedge clk);
    #1;
    chk("dropped", {gnt_n, hold, oe}, 3'b101);
  endtask : t_refuse
  initial begin
    repeat (3) @(posedge clk);
    #1;
    chk("reset", {gnt_n, hold, oe, adb, stl, as_n, ds_n, rw, bw, ns, mrq},
        {3'b101, 16'h0000, 4'h0, 6'h2f});
    @(posedge clk) sys_rst <= 0;
    @(posedge clk) #1;
    t_values;
    t_single;
    t_contend;
    t_retry;
    t_refuse;
    t_reset;
    results;
  end
  // hang guard, far beyond the hundred or so cycles the run needs
  initial begin
    #20000;
    n_errors++;
    results;
  end
endmodule : tb_top
